/* File: include/reset_ctrl_pkg.sv */
/*
  Constants for the analog die reset control block: register offset, cause
  field positions and reset timing. Assumes a 200 MHz core clock.
*/
package reset_ctrl_pkg;

  localparam int unsigned CLK_PERIOD_PS              = 5000;

  // Register map.
  localparam logic [7:0]  RESET_CAUSE_STATUS_OFFSET  = 8'h15;
  localparam logic [7:0]  RESET_CAUSE_STATUS_RESET   = 8'h01;

  // Cause field positions.
  localparam int unsigned POWER_ON_BIT               = 0;
  localparam int unsigned CORE_LOW_VOLT_BIT          = 1;
  localparam int unsigned IO_LOW_VOLT_BIT            = 2;
  localparam int unsigned SLEEP_WAKEUP_BIT           = 3;
  localparam int unsigned EXTERNAL_BIT               = 4;
  localparam int unsigned WATCHDOG_BIT               = 5;
  localparam int unsigned CAUSE_COUNT                = 6;

  // Timing, in nanoseconds as printed defaults, and derived cycle counts.
  localparam int unsigned RESET_EXTEND_TIME_NS       = 4000;
  localparam int unsigned EXTERNAL_RESET_FILTER_TIME_NS = 1000;
  localparam int unsigned RESET_EXTEND_CYCLES        =
    (RESET_EXTEND_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned FILTER_CYCLES              =
    (EXTERNAL_RESET_FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int unsigned COUNT_WIDTH                = 16;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP
  } power_mode_t;

endpackage

/* File: rtl/analog_die_reset_control.sv */
/*
  Reset generation and reset cause recording for the analog die. Drives the
  shared active-low reset pin, filters it for external resets and keeps the
  clear-on-read cause register. Assumes condition inputs from the regulator
  monitors, the watchdog and the wake-up logic; asynchronous ones are
  synchronised here.
*/
// Overview of operation
// - Reset pin is driven low while any internal reset condition exists.
// - Reset pin level is watched to detect external resets.
// - Pin stays low a fixed extension time after internal conditions end.
// - Entering reset mode returns die registers to defaults, except cause and wake.
// - Only cause and wake-up source registers keep contents across reset.
// - Six distinct reset causes, one flag each.
// - Power-on flag set on low main supply or power-up.
// - Core regulator low voltage raises core low-voltage reset.
// - I/O regulator low voltage raises I/O low-voltage reset.
// - I/O low voltage shuts down core regulator.
// - Wake-up in sleep enters reset and records wake-up cause.
// - Pin low longer than filter time is an external reset; not detected in sleep mode.
// - External reset detection also works in stop mode.
// - Bad watchdog service gives watchdog reset and cause.
// - Cause register at 0x15, bits 5..0 causes, bits 7..6 zero.
// - Reading the cause register clears it; writes do nothing.
// - Low-voltage flags masked while power-on or wake-up flag set.
// - Stop-mode core low voltage or external reset enters reset directly.
module analog_die_reset_control
  import reset_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Condition inputs from monitors, asynchronous
  input  wire logic       main_supply_low,
  input  wire logic       core_low_volt,
  input  wire logic       io_low_volt,
  // Same-clock events
  input  wire logic       sleep_wakeup_event,
  input  wire logic       watchdog_fail,
  input  wire power_mode_t power_mode,
  // Shared reset pin, open drain
  input  wire logic       reset_pin_in,
  output logic            reset_pin_out,
  output logic            reset_pin_oe,
  // Register access port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_read,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Control outputs
  output logic            core_regulator_shutdown,
  output logic            die_register_reset,
  output logic            reset_mode
);

  logic                   supply_sync_a;
  logic                   supply_sync_b;
  logic                   core_sync_a;
  logic                   core_sync_b;
  logic                   io_sync_a;
  logic                   io_sync_b;
  logic                   external_low;
  logic                   external_low_q;
  logic                   external_event;
  logic                   sleep_wake_reset;
  logic                   watchdog_pending;
  logic                   internal_active;
  logic [COUNT_WIDTH-1:0] extend_count;
  logic                   extending;
  logic                   reset_mode_q;
  logic [5:0]             cause;
  logic [5:0]             set_cause;
  logic                   read_cause;
  logic [7:0]             cause_view;

  // Monitor levels come from analog comparators, so two flops each.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_sync_a <= 1'b0;
      supply_sync_b <= 1'b0;
      core_sync_a   <= 1'b0;
      core_sync_b   <= 1'b0;
      io_sync_a     <= 1'b0;
      io_sync_b     <= 1'b0;
    end else begin
      supply_sync_a <= main_supply_low;
      supply_sync_b <= supply_sync_a;
      core_sync_a   <= core_low_volt;
      core_sync_b   <= core_sync_a;
      io_sync_a     <= io_low_volt;
      io_sync_b     <= io_sync_a;
    end
  end

  // The filter sees the pin, including our own drive; self-driven lows
  // are excluded below so the die does not latch its own reset as external.
  low_level_filter #(
    .LIMIT     (FILTER_CYCLES)
  ) u_pin_filter (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_level (reset_pin_in),
    .held_low  (external_low)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      external_low_q <= 1'b0;
    end else begin
      external_low_q <= external_low;
    end
  end

  // Sleep mode has no pin detection; normal and stop both detect.
  assign external_event = external_low && !external_low_q && !reset_pin_oe &&
                          (power_mode != MODE_SLEEP);

  assign sleep_wake_reset = sleep_wakeup_event && (power_mode == MODE_SLEEP);

  // The watchdog failure is a pulse, so it is held for one reset cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_pending <= 1'b0;
    end else begin
      watchdog_pending <= watchdog_fail;
    end
  end

  assign core_regulator_shutdown = io_sync_b;

  // Core low voltage also reads true during the shutdown that I/O low
  // voltage causes, which is why both flags can appear together.
  assign internal_active = supply_sync_b || core_sync_b || io_sync_b ||
                           watchdog_pending || sleep_wake_reset;

  // Reset extension counter, reloaded while any condition is present.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extend_count <= COUNT_WIDTH'(RESET_EXTEND_CYCLES);
      extending    <= 1'b1;
    end else if (internal_active || external_event) begin
      extend_count <= COUNT_WIDTH'(RESET_EXTEND_CYCLES);
      extending    <= 1'b1;
    end else if (extend_count != '0) begin
      extend_count <= extend_count - COUNT_WIDTH'(1);
    end else begin
      extending    <= 1'b0;
    end
  end

  // Stop mode events go straight to reset with no intermediate state.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_mode_q <= 1'b1;
    end else begin
      reset_mode_q <= internal_active || external_event || extending;
    end
  end

  assign reset_mode = reset_mode_q;

  // Open-drain pin: drive low only, enable high while driving.
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = internal_active || extending;

  // The die's other registers take this as their synchronous clear; the
  // cause register here does not.
  assign die_register_reset = reset_mode_q;

  always_comb begin
    set_cause                    = '0;
    set_cause[POWER_ON_BIT]      = supply_sync_b;
    set_cause[CORE_LOW_VOLT_BIT] = core_sync_b;
    set_cause[IO_LOW_VOLT_BIT]   = io_sync_b;
    set_cause[SLEEP_WAKEUP_BIT]  = sleep_wake_reset;
    set_cause[EXTERNAL_BIT]      = external_event;
    set_cause[WATCHDOG_BIT]      = watchdog_pending;
  end

  assign read_cause = reg_read && (reg_addr == RESET_CAUSE_STATUS_OFFSET);

  // A set in the same cycle as the clearing read survives it.
  // Power-up leaves the power-on flag set through the async reset.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause <= RESET_CAUSE_STATUS_RESET[5:0];
    end else if (read_cause) begin
      cause <= set_cause;
    end else begin
      cause <= cause | set_cause;
    end
  end

  // Low-voltage flags are hidden, not cleared, while masked.
  always_comb begin
    cause_view = {2'b00, cause};
    if (cause[POWER_ON_BIT] || cause[SLEEP_WAKEUP_BIT]) begin
      cause_view[CORE_LOW_VOLT_BIT] = 1'b0;
      cause_view[IO_LOW_VOLT_BIT]   = 1'b0;
    end
  end

  // Writes are accepted on the port but store nothing.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (read_cause) begin
      reg_rdata <= cause_view;
    end else if (reg_read || reg_write) begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* File: rtl/low_level_filter.sv */
/*
  Synchronises a pin level and reports when it has been low for more than
  a given number of cycles. Assumes an asynchronous pin and one clock.
*/
module low_level_filter
  import reset_ctrl_pkg::*;
#(
  parameter int unsigned LIMIT = 4
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Pin side
  input  wire logic pin_level,
  // Result
  output logic      held_low
);

  logic                   sync_a;
  logic                   sync_b;
  logic [COUNT_WIDTH-1:0] low_count;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= pin_level;
      sync_b <= sync_a;
    end
  end

  // The count saturates so that a long hold keeps the result asserted.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_count <= '0;
      held_low  <= 1'b0;
    end else if (sync_b) begin
      low_count <= '0;
      held_low  <= 1'b0;
    end else if (low_count > COUNT_WIDTH'(LIMIT)) begin
      held_low  <= 1'b1;
    end else begin
      low_count <= low_count + COUNT_WIDTH'(1);
    end
  end

endmodule

/* File: verification/analog_die_reset_control_tb.sv */
/*
  Self-checking bench for the reset control block with the controller model
  on the reset line. Assumes the 200 MHz clock and inputs driven on falling edges.
*/
module analog_die_reset_control_tb
  import reset_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0, rst_n = 1'b0, pull_low = 1'b0;
  logic        main_supply_low = 1'b0, core_low_volt = 1'b0, io_low_volt = 1'b0;
  logic        sleep_wakeup_event = 1'b0, watchdog_fail = 1'b0, reg_read = 1'b0, reg_write = 1'b0;
  power_mode_t power_mode = MODE_NORMAL;
  logic        reset_pin_in, reset_pin_out, reset_pin_oe;
  logic        core_regulator_shutdown, die_register_reset, reset_mode;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd, other_addr;
  logic [31:0] lfsr = 32'h13C871F7;
  int          fails = 0, compares = 0, cyc = 0, n;
  analog_die_reset_control u_analog_die_reset_control (.core_clk(core_clk), .rst_n(rst_n),
    .main_supply_low(main_supply_low), .core_low_volt(core_low_volt),
    .io_low_volt(io_low_volt), .sleep_wakeup_event(sleep_wakeup_event),
    .watchdog_fail(watchdog_fail), .power_mode(power_mode), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .reg_addr(reg_addr),
    .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .core_regulator_shutdown(core_regulator_shutdown),
    .die_register_reset(die_register_reset), .reset_mode(reset_mode));
  mcu_model u_mcu_model (.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .pull_low(pull_low), .pin_level(reset_pin_in));
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // Stored flags as software sees them, with the low-voltage masking applied.
  function automatic logic [7:0] exp_read(logic [7:0] stored);
    return (stored[0] || stored[3]) ? (stored & 8'h39) : stored;
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_n(int c);
    repeat (c) @(negedge core_clk);
  endtask
  task automatic access(logic wr, logic [7:0] a);
    reg_addr = a;
    reg_wdata = 8'(next_rand());
    {reg_write, reg_read} = {wr, !wr};
    @(negedge core_clk);
    {reg_write, reg_read} = 2'b00;
    rd = reg_rdata;
    @(negedge core_clk);
  endtask
  // Waits for the pin to be driven, then counts the cycles until release.
  task automatic settle();
    for (int i = 0; i < 400 && reset_pin_oe !== 1'b1; i++) @(negedge core_clk);
    check("pin", {7'h00, reset_pin_in}, 8'h00);
    n = 0;
    while (reset_pin_oe === 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
      if (n == 2) check("mode", {6'h00, reset_mode, die_register_reset}, 8'h03);
    end
    power_mode = MODE_NORMAL;
    check("hold", {7'h00, n + 8 >= RESET_EXTEND_CYCLES &&
                   n <= RESET_EXTEND_CYCLES + 8}, 8'h01);
  endtask
  task automatic cause(int k);
    case (k)
      0: main_supply_low = 1'b1;
      1: core_low_volt = 1'b1;
      2: io_low_volt = 1'b1;
      3: {power_mode, sleep_wakeup_event} = {MODE_SLEEP, 1'b1};
      4: {power_mode, pull_low} = {MODE_STOP, 1'b1};
      default: watchdog_fail = 1'b1;
    endcase
    @(negedge core_clk);
    {sleep_wakeup_event, watchdog_fail} = 2'b00;
    for (int i = 0; i < FILTER_CYCLES + 20 && reset_pin_oe !== 1'b1; i++) @(negedge core_clk);
    if (k < 3) wait_n(10);
    if (k == 2) check("shutdown", {7'h00, core_regulator_shutdown}, 8'h01);
    {main_supply_low, core_low_volt, io_low_volt, pull_low} = 4'h0;
  endtask
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    wait_n(5);
    rst_n = 1'b1;
    settle();
    access(1'b0, RESET_CAUSE_STATUS_OFFSET);
    check("power-up", rd, exp_read(8'h01));
    access(1'b1, RESET_CAUSE_STATUS_OFFSET);
    access(1'b0, RESET_CAUSE_STATUS_OFFSET);
    check("cleared", rd, 8'h00);
    other_addr = 8'(next_rand());
    access(1'b0, other_addr == RESET_CAUSE_STATUS_OFFSET ? 8'h16 : other_addr);
    check("other", rd, 8'h00);
    {power_mode, pull_low} = {MODE_STOP, 1'b1};
    wait_n(next_rand() % (FILTER_CYCLES - 20) + 1);
    pull_low = 1'b0;
    wait_n(10);
    check("glitch", {7'h00, reset_pin_oe}, 8'h00);
    for (int k = 0; k < CAUSE_COUNT; k++) begin
      wait_n(next_rand() % 16 + 2);
      cause(k);
      settle();
      access(1'b0, RESET_CAUSE_STATUS_OFFSET);
      check("cause", rd & (k == 2 ? 8'h04 : 8'hFF), exp_read(8'h01 << k));
    end
    cause(3);
    cause(1);
    settle();
    access(1'b0, RESET_CAUSE_STATUS_OFFSET);
    check("masked", rd, exp_read(8'h0A));
    access(1'b0, RESET_CAUSE_STATUS_OFFSET);
    check("reread", rd, 8'h00);
    // A second power-up in mid-run must bring back the power-on flag alone.
    rst_n = 1'b0;
    wait_n(2);
    rst_n = 1'b1;
    settle();
    access(1'b0, RESET_CAUSE_STATUS_OFFSET);
    check("restart", rd, exp_read(8'h01));
    summarize();
  end
endmodule

/* File: verification/mcu_model.sv */
/*
  Companion controller on the shared reset line: it may pull the line low.
  Assumes a pull-up on the line and an open-drain driver on the die.
*/
module mcu_model (
  // Die side of the pin
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe,
  // Controller side
  input  wire logic pull_low,
  output logic      pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // The pull-up wins only while neither party drives the line.
  assign pin_level = reset_pin_oe ? reset_pin_out : !pull_low;
endmodule

/* File: verification/reset_ctrl_monitor.sv */
/*
  Checker for the analog die reset control block, bound to its top ports.
  Assumes one core clock and rst_n as the only reset.
*/
module reset_ctrl_monitor
  import reset_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Cause inputs
  input wire logic        core_low_volt,
  input wire logic        sleep_wakeup_event,
  input wire logic        watchdog_fail,
  input wire power_mode_t power_mode,
  // Pin and register port
  input wire logic        reset_pin_in,
  input wire logic        reset_pin_oe,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  // Control outputs
  input wire logic        core_regulator_shutdown,
  input wire logic        die_register_reset,
  input wire logic        reset_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // Slack covers the pin synchroniser and filter pipeline.
  localparam int unsigned EXT_LIMIT = FILTER_CYCLES + 8;
  int unsigned oe_cnt;
  int unsigned ext_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) oe_cnt <= 0;
    else oe_cnt <= reset_pin_oe ? oe_cnt + 1 : 0;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) ext_cnt <= 0;
    else if (!reset_pin_in && !reset_pin_oe && power_mode != MODE_SLEEP) ext_cnt <= ext_cnt + 1;
    else ext_cnt <= 0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rsv; reg_rdata[7:6] == 2'b00; endproperty
  property p_other; reg_read && reg_addr != RESET_CAUSE_STATUS_OFFSET |=> reg_rdata == 8'h00;
  endproperty
  property p_mask; (reg_rdata[0] || reg_rdata[3]) |-> reg_rdata[2:1] == 2'b00; endproperty
  property p_shut; core_regulator_shutdown |-> reset_pin_oe; endproperty
  property p_extend; $fell(reset_pin_oe) |-> oe_cnt >= RESET_EXTEND_CYCLES; endproperty
  property p_wdog; watchdog_fail |-> ##[1:4] reset_pin_oe; endproperty
  property p_core; core_low_volt [*4] |-> reset_pin_oe; endproperty
  property p_wake;
    sleep_wakeup_event && power_mode == MODE_SLEEP |-> ##[1:3] reset_mode;
  endproperty
  // Entering reset is seen on the pin itself as well as on the mode flop.
  property p_die;
    (reset_mode || $rose(reset_pin_oe)) |-> ##[0:2] die_register_reset;
  endproperty
  property p_ext; ext_cnt <= EXT_LIMIT; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  a_other: assert property (p_other) else $error("other address read nonzero");
  a_mask: assert property (p_mask) else $error("low voltage flags not masked");
  a_shut: assert property (p_shut) else $error("shutdown without reset");
  a_extend: assert property (p_extend) else $error("pin released early");
  a_wdog: assert property (p_wdog) else $error("watchdog reset missing");
  a_core: assert property (p_core) else $error("core low voltage reset missing");
  a_wake: assert property (p_wake) else $error("no reset mode on wake");
  a_die: assert property (p_die) else $error("registers not cleared");
  a_ext: assert property (p_ext) else $error("external reset missed");
  c_wdog: cover property (watchdog_fail ##[1:4] reset_pin_oe);
  c_release: cover property ($fell(reset_pin_oe));
  c_ext: cover property (reg_read && reg_addr == RESET_CAUSE_STATUS_OFFSET ##1 reg_rdata[4]);
endmodule
bind analog_die_reset_control reset_ctrl_monitor u_reset_ctrl_monitor (.core_clk(core_clk),
  .rst_n(rst_n), .core_low_volt(core_low_volt), .sleep_wakeup_event(sleep_wakeup_event),
  .watchdog_fail(watchdog_fail), .power_mode(power_mode), .reset_pin_in(reset_pin_in),
  .reset_pin_oe(reset_pin_oe), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .core_regulator_shutdown(core_regulator_shutdown),
  .die_register_reset(die_register_reset), .reset_mode(reset_mode));
